// *** aaie_defs.vh ***
// constants for the add/and execution datapath
`ifndef AAIE_DEFS_VH
`define AAIE_DEFS_VH
// register offsets (APB byte addresses)
`define AAIE_OFF_INSTR 12'h000
`define AAIE_OFF_ACC 12'h004
`define AAIE_OFF_STATUS 12'h008
`define AAIE_OFF_CTRL 12'h00C
`define AAIE_OFF_PINS 12'h010
`define AAIE_OFF_FILE 12'h200
// opcode patterns
`define AAIE_OP_ADDLIT 5'h1F
`define AAIE_OP_ANDLIT 6'h39
`define AAIE_OP_ADDFILE 6'h07
`define AAIE_OP_ANDFILE 6'h05
// field positions
`define AAIE_DEST_BIT 7
`define AAIE_ST_C 0
`define AAIE_ST_DC 1
`define AAIE_ST_Z 2
`define AAIE_ST_BUSY 3
`define AAIE_CTRL_PSA 0
`define AAIE_CTRL_PCMOD 1
// special file addresses
`define AAIE_ADDR_TIMER 7'h01
`define AAIE_ADDR_PORTA 7'h05
`define AAIE_ADDR_SECOND_IO_PORT 7'h06
// reset values
`define AAIE_RST_ACC 8'h00
`define AAIE_RST_CTRL 2'h1
`define AAIE_RST_INSTR 14'h0000
`endif

// *** aaie_alu.v ***
// arithmetic/logic unit for add and and operations
`timescale 1ns/1ns
module aaie_alu (
	input wire [7:0] a, // first operand
	input wire [7:0] b, // second operand
	input wire do_and, // select and instead of add
	output reg [7:0] res, // result
	output reg carry, // carry out of bit 7
	output reg dcarry, // carry out of bit 3
	output reg zero // result is zero
);
	reg [4:0] lo;
	reg [8:0] full;
	always @* begin
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		full = {1'b0, a} + {1'b0, b};
		if (do_and) begin
			res = a & b;
		end else begin
			res = full[7:0];
		end
		carry = full[8];
		dcarry = lo[4];
		zero = (res == 8'h00);
	end
endmodule // aaie_alu

// *** aaie_core.v ***
// execution datapath top with apb register access
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "aaie_defs.vh"
module aaie_core (
	input wire CORE_CLK, // core clock
	input wire RESET_N, // sync reset, active low
	input wire PSEL, // apb select
	input wire PENABLE, // apb enable
	input wire PWRITE, // apb direction
	input wire [11:0] PADDR, // apb byte address
	input wire [31:0] PWDATA, // apb write data
	input wire [7:0] PORTA_PINS, // sensed levels, first port
	input wire [7:0] SECOND_IO_PORT_PINS, // sensed levels, second port
	output reg [31:0] PRDATA, // apb read data
	output reg PREADY, // apb ready
	output reg PSLVERR, // apb error
	output reg PRESCALER_CLR, // prescaler clear pulse
	output reg EXEC_DONE // instruction retired pulse
);
	// --------------------------------------------------------------
	// state and storage
	// --------------------------------------------------------------
	localparam ST_IDLE = 2'b01;
	localparam ST_NOP = 2'b10;
	reg [1:0] state_q;
	reg [7:0] acc_q;
	reg c_q;
	reg dc_q;
	reg z_q;
	reg [1:0] ctrl_q;
	reg [13:0] instr_q;
	reg [7:0] file_q [0:127];
	wire idle = (state_q == ST_IDLE);
	wire busy = ~idle;
	wire pcmod = ctrl_q[`AAIE_CTRL_PCMOD];
	wire psa = ctrl_q[`AAIE_CTRL_PSA];
	// one wait state: ready answers the first access cycle
	wire access = PSEL & PENABLE & ~PREADY;
	wire wr = access & PWRITE;
	wire hit_instr = (PADDR == `AAIE_OFF_INSTR);
	wire hit_acc = (PADDR == `AAIE_OFF_ACC);
	wire hit_status = (PADDR == `AAIE_OFF_STATUS);
	wire hit_ctrl = (PADDR == `AAIE_OFF_CTRL);
	wire hit_pins = (PADDR == `AAIE_OFF_PINS);
	wire file_hit = (PADDR[11:9] == 3'h1) & (PADDR[1:0] == 2'b00);
	wire [6:0] paddr_f = PADDR[8:2];
	wire start = wr & hit_instr & idle;
	wire wr_acc = wr & hit_acc;
	wire wr_ctrl = wr & hit_ctrl;
	// an instruction write-back wins over a bus write
	wire wr_file_bus = wr & file_hit & ~start;
	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	wire [13:0] iw = PWDATA[13:0];
	wire is_addlit = (iw[13:9] == `AAIE_OP_ADDLIT);
	wire is_andlit = (iw[13:8] == `AAIE_OP_ANDLIT);
	wire is_addf = (iw[13:8] == `AAIE_OP_ADDFILE);
	wire is_andf = (iw[13:8] == `AAIE_OP_ANDFILE);
	wire is_file = is_addf | is_andf;
	wire do_and = is_andlit | is_andf;
	wire dest_f = iw[`AAIE_DEST_BIT];
	wire [6:0] faddr = iw[6:0];
	wire [7:0] lit = iw[7:0];
	// rmw source: pin levels stand in for port latches
	reg [7:0] src;
	always @* begin
		if (faddr == `AAIE_ADDR_PORTA) begin
			src = PORTA_PINS;
		end else if (faddr == `AAIE_ADDR_SECOND_IO_PORT) begin
			src = SECOND_IO_PORT_PINS;
		end else begin
			src = file_q[faddr];
		end
	end
	wire [7:0] opb = is_file ? src : lit;
	wire [7:0] res;
	wire alu_c;
	wire alu_dc;
	wire alu_z;
	aaie_alu u_alu (
		.a(acc_q),
		.b(opb),
		.do_and(do_and),
		.res(res),
		.carry(alu_c),
		.dcarry(alu_dc),
		.zero(alu_z)
	);
	wire known = is_addlit | is_andlit | is_file;
	wire upd_cdc = is_addlit | is_addf;
	wire wr_file = is_file & dest_f;
	// --------------------------------------------------------------
	// execution and registers
	// --------------------------------------------------------------
	integer i;
	always @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			state_q <= ST_IDLE;
			acc_q <= `AAIE_RST_ACC;
			c_q <= 1'b0;
			dc_q <= 1'b0;
			z_q <= 1'b0;
			ctrl_q <= `AAIE_RST_CTRL;
			instr_q <= `AAIE_RST_INSTR;
			PRESCALER_CLR <= 1'b0;
			EXEC_DONE <= 1'b0;
			for (i = 0; i < 128; i = i + 1) begin
				file_q[i] <= 8'h00;
			end
		end else begin
			PRESCALER_CLR <= 1'b0;
			EXEC_DONE <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						instr_q <= iw;
						if (known) begin
							if (wr_file) begin
								file_q[faddr] <= res;
							end else begin
								acc_q <= res;
							end
							z_q <= alu_z;
							if (upd_cdc) begin
								c_q <= alu_c;
								dc_q <= alu_dc;
							end
							if (wr_file && faddr == `AAIE_ADDR_TIMER && psa) begin
								PRESCALER_CLR <= 1'b1;
							end
						end
						if (pcmod) begin
							state_q <= ST_NOP;
						end else begin
							EXEC_DONE <= 1'b1;
						end
					end
				end
				ST_NOP: begin
					// second cycle changes nothing, then retires
					state_q <= ST_IDLE;
					EXEC_DONE <= 1'b1;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			// bus writes to acc, ctrl and the file array
			if (wr_acc) begin
				acc_q <= PWDATA[7:0];
			end
			if (wr_ctrl) begin
				ctrl_q <= PWDATA[1:0];
			end
			if (wr_file_bus) begin
				file_q[paddr_f] <= PWDATA[7:0];
			end
		end
	end
	// --------------------------------------------------------------
	// apb read mux and response
	// --------------------------------------------------------------
	reg [31:0] status_rd;
	reg [31:0] rdata_d;
	reg err_d;
	// status flags at their own bit positions
	always @* begin
		status_rd = 32'h00000000;
		status_rd[`AAIE_ST_C] = c_q;
		status_rd[`AAIE_ST_DC] = dc_q;
		status_rd[`AAIE_ST_Z] = z_q;
		status_rd[`AAIE_ST_BUSY] = busy;
	end
	always @* begin
		rdata_d = 32'h00000000;
		err_d = 1'b0;
		if (hit_instr) begin
			rdata_d = {18'h00000, instr_q};
			err_d = PWRITE & busy;
		end else if (hit_acc) begin
			rdata_d = {24'h000000, acc_q};
		end else if (hit_status) begin
			rdata_d = status_rd;
			err_d = PWRITE;
		end else if (hit_ctrl) begin
			rdata_d = {30'h00000000, ctrl_q};
		end else if (hit_pins) begin
			rdata_d = {16'h0000, SECOND_IO_PORT_PINS, PORTA_PINS};
			err_d = PWRITE;
		end else if (file_hit) begin
			rdata_d = {24'h000000, file_q[paddr_f]};
		end else begin
			err_d = 1'b1;
		end
	end
	always @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			if (access) begin
				PREADY <= 1'b1;
				PRDATA <= rdata_d;
				PSLVERR <= err_d;
			end
		end
	end
endmodule // aaie_core

// *** aaie_props.sv ***
// port checker for the add/and datapath
`timescale 1ns/1ns
`include "aaie_defs.vh"
module aaie_props (
	input wire CORE_CLK, // clock
	input wire RESET_N, // reset
	input wire PSEL, // select
	input wire PENABLE, // enable
	input wire PWRITE, // direction
	input wire [11:0] PADDR, // address
	input wire [31:0] PRDATA, // read data
	input wire PREADY, // ready
	input wire PSLVERR, // error
	input wire PRESCALER_CLR, // clear pulse
	input wire EXEC_DONE // retire pulse
);
	// ----
	// properties
	// ----
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	wire acc = PSEL && PENABLE;
	wire iw = acc && PWRITE && PADDR == `AAIE_OFF_INSTR;
	property p_wait; acc && !PREADY |=> PREADY; endproperty
	a_wait: assert property (p_wait) else $error("ready late");
	property p_pulse; PREADY |=> !PREADY; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_cause; PREADY |-> acc && $past(acc); endproperty
	a_cause: assert property (p_cause) else $error("stray ready");
	property p_err; PSLVERR |-> PREADY; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_clr; PRESCALER_CLR |-> PREADY && $past(iw); endproperty
	a_clr: assert property (p_clr) else $error("stray clear");
	property p_clr1; PRESCALER_CLR |=> !PRESCALER_CLR; endproperty
	a_clr1: assert property (p_clr1) else $error("clear held");
	property p_done; EXEC_DONE |-> $past(iw) || $past(iw, 2); endproperty
	a_done: assert property (p_done) else $error("stray done");
	property p_unmap; PREADY && !PWRITE && PADDR == 12'h400 |-> PSLVERR && PRDATA == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	cover property (PRESCALER_CLR);
	cover property (EXEC_DONE);
	cover property (PSLVERR);
endmodule // aaie_props
bind aaie_core aaie_props u_props (
	.CORE_CLK(CORE_CLK),
	.RESET_N(RESET_N),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PRDATA(PRDATA),
	.PREADY(PREADY),
	.PSLVERR(PSLVERR),
	.PRESCALER_CLR(PRESCALER_CLR),
	.EXEC_DONE(EXEC_DONE)
);

// *** test_add_and_instruction_exec.sv ***
// self-checking bench for the add/and datapath
`timescale 1ns/1ns
module test_add_and_instruction_exec;
	reg CORE_CLK = 1'h0, RESET_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
	reg [11:0] PADDR = 12'h0;
	reg [31:0] PWDATA = 32'h0;
	reg [7:0] PORTA_PINS = 8'h0, SECOND_IO_PORT_PINS = 8'h0;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, PRESCALER_CLR, EXEC_DONE;
	integer miscompares = 0, checked = 0, cyc = 0;
	reg [31:0] rd, er, clr, dn;
	aaie_core dut (
		.CORE_CLK(CORE_CLK),
		.RESET_N(RESET_N),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PORTA_PINS(PORTA_PINS),
		.SECOND_IO_PORT_PINS(SECOND_IO_PORT_PINS),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.PRESCALER_CLR(PRESCALER_CLR),
		.EXEC_DONE(EXEC_DONE)
	);
	// ----
	// clock, timeout, tasks
	// ----
	initial forever #2 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end
	task end_of_test;
		if (miscompares == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task c(input [31:0] g, input [31:0] e);
		checked = checked + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task x(input [11:0] a, input w, input [31:0] d);
		PADDR <= a;
		PWRITE <= w;
		PWDATA <= d;
		PSEL <= 1'h1;
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		do @(posedge CORE_CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		er = {31'h0, PSLVERR};
		clr = {31'h0, PRESCALER_CLR};
		dn = {31'h0, EXEC_DONE};
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CORE_CLK);
	endtask
	task op(input [31:0] a, input [31:0] i, input [31:0] ea, input [31:0] es, input [31:0] ef);
		x(12'h280, 1'h1, 32'hC2);
		x(12'h004, 1'h1, a);
		x(12'h000, 1'h1, i);
		x(12'h004, 1'h0, 32'h0);
		c(rd, ea);
		c(er, 32'h0);
		x(12'h008, 1'h0, 32'h0);
		c(rd, es);
		x(12'h280, 1'h0, 32'h0);
		c(rd, ef);
	endtask
	task pc(input [31:0] k, input [31:0] i, input [31:0] e);
		x(12'h00C, 1'h1, k);
		x(12'h000, 1'h1, i);
		c(clr, e);
		c(dn, 32'h1);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (8) @(posedge CORE_CLK);
		RESET_N <= 1'h1;
		x(12'h00C, 1'h0, 32'h0);
		c(rd, 32'h1);
		op(32'h10, 32'h3E15, 32'h25, 32'h0, 32'hC2);
		op(32'h88, 32'h3F78, 32'h0, 32'h7, 32'hC2);
		op(32'hA3, 32'h395F, 32'h3, 32'h3, 32'hC2);
		op(32'h0F, 32'h39F0, 32'h0, 32'h7, 32'hC2);
		op(32'h17, 32'h0720, 32'hD9, 32'h0, 32'hC2);
		op(32'h17, 32'h05A0, 32'h17, 32'h0, 32'h2);
		op(32'h3E, 32'h07A0, 32'h3E, 32'h7, 32'h0);
		op(32'h3D, 32'h0520, 32'h0, 32'h7, 32'hC2);
		pc(32'h1, 32'h0781, 32'h1);
		pc(32'h1, 32'h0701, 32'h0);
		pc(32'h0, 32'h0781, 32'h0);
		PORTA_PINS <= 8'h3C;
		SECOND_IO_PORT_PINS <= 8'h5A;
		x(12'h218, 1'h1, 32'hFF);
		x(12'h004, 1'h1, 32'h0);
		x(12'h000, 1'h1, 32'h0786);
		x(12'h218, 1'h0, 32'h0);
		c(rd, 32'h5A);
		x(12'h010, 1'h0, 32'h0);
		c(rd, 32'h5A3C);
		x(12'h008, 1'h1, 32'hF);
		c(er, 32'h1);
		x(12'h3FC, 1'h1, 32'h5A);
		x(12'h3FC, 1'h0, 32'h0);
		c(rd, 32'h5A);
		x(12'h400, 1'h0, 32'h0);
		c(er, 32'h1);
		x(12'h00C, 1'h1, 32'h2);
		x(12'h004, 1'h1, 32'h1);
		x(12'h000, 1'h1, 32'h3E01);
		c(dn, 32'h0);
		c({31'h0, EXEC_DONE}, 32'h1);
		x(12'h004, 1'h0, 32'h0);
		c(rd, 32'h2);
		end_of_test;
	end
endmodule // test_add_and_instruction_exec
